//--- logic/ucrs_pkg.sv
// Purpose: constants and types for the channel register set of a uart
// Assumes: 32-bit axi4-lite data, one register per aligned word
// Notes: registers are 8 bits wide and sit in the low byte lanes
package ucrs_pkg;
    // ==========================================================
    // bus geometry and responses
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_HOLD = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_IER = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_ISR_FCR = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_LCR = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_MCR = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_LSR = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_MSR = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_SCRATCH = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_FEATURE_CONTROL = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_EFR = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_TXLVL = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_RXLVL = 8'h2C;
    localparam logic [ADDR_W-1:0] OFF_XSTAT = 8'h30;
    localparam logic [ADDR_W-1:0] OFF_RES1 = 8'h34;
    localparam logic [ADDR_W-1:0] OFF_RES2 = 8'h38;
    localparam logic [ADDR_W-1:0] OFF_PAU1 = 8'h3C;
    localparam logic [ADDR_W-1:0] OFF_PAU2 = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_DIVLO = 8'h44;
    localparam logic [ADDR_W-1:0] OFF_DIVHI = 8'h48;
    localparam logic [ADDR_W-1:0] OFF_DIVFR = 8'h4C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h50;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h54;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h58;
    // ==========================================================
    // reset values
    localparam logic [REG_W-1:0] RST_ZERO = 8'h00;
    localparam logic [REG_W-1:0] RST_DIVLO = 8'h01;
    localparam logic [REG_W-1:0] RST_ISR = 8'h01;
    localparam logic [REG_W-1:0] RST_LSR = 8'h60;
    localparam logic [REG_W-1:0] RST_SCRATCH = 8'hFF;
    // ==========================================================
    // field positions and widths
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MSR_DELTA_LSB = 0;
    localparam int MSR_LEVEL_LSB = 4;
    localparam int MODEM_N = 4;
    localparam int EFR_SWFC_LSB = 0;
    localparam int EFR_SWFC_W = 4;
    localparam int XC_RX_XOFF = 0;
    localparam int XC_RX_XON = 1;
    localparam int XC_TX_XOFF = 2;
    localparam int XC_TX_XON = 3;
    localparam int XC_W = 4;
    localparam int IRQ_N = 5;
    localparam int IRQ_MODEM = 4;
    // ==========================================================
    // write channel states
    typedef enum logic [1:0] {
        UCRS_WS_IDLE = 2'h1,
        UCRS_WS_RESP = 2'h2
    } ucrs_wstate_e;
endpackage : ucrs_pkg

//--- logic/ucrs_top.sv
// Purpose: one uart channel register set with reset and power-up state
// Assumes: all inputs synchronous to clk_sys; flow engine and fifos outside
// Notes: power-up reset also loads divLow and divHigh; srst leaves them but clears divFrac
`timescale 1ns/1ps
`default_nettype none
module ucrs_top
    import ucrs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic porRst,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [DATA_W/8-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // channel side
    input wire logic [MODEM_N-1:0] modemIn,
    input wire logic rxXoffDet,
    input wire logic rxXonDet,
    input wire logic txXoffSent,
    input wire logic txXonSent,
    input wire logic txSerial,
    input wire logic [REG_W-1:0] rxHoldData,
    input wire logic [REG_W-1:0] isrIn,
    input wire logic [REG_W-1:0] lsrIn,
    input wire logic [REG_W-1:0] txLevelIn,
    input wire logic [REG_W-1:0] rxLevelIn,
    output logic txOut,
    output logic rtsN,
    output logic dtrN,
    output logic txHoldStb,
    output logic [REG_W-1:0] txHoldData,
    output logic [REG_W-1:0] divLow,
    output logic [REG_W-1:0] divHigh,
    output logic [REG_W-1:0] divFrac,
    output logic [REG_W-1:0] intEnable,
    output logic [REG_W-1:0] fifoCtrl,
    output logic [REG_W-1:0] lineCtrl,
    output logic [REG_W-1:0] modemCtrl,
    output logic [REG_W-1:0] featureCtrl,
    output logic [REG_W-1:0] enhFeature,
    output logic [REG_W-1:0] txTrigger,
    output logic [REG_W-1:0] rxTrigger,
    output logic [REG_W-1:0] resumeCharOne,
    output logic [REG_W-1:0] resumeCharTwo,
    output logic [REG_W-1:0] pauseCharOne,
    output logic [REG_W-1:0] pauseCharTwo,
    output logic irq
);
    // ==========================================================
    // decode helpers
    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        case (a)
            OFF_HOLD, OFF_IER, OFF_ISR_FCR, OFF_LCR, OFF_MCR, OFF_LSR,
            OFF_MSR, OFF_SCRATCH, OFF_FEATURE_CONTROL, OFF_EFR, OFF_TXLVL, OFF_RXLVL,
            OFF_XSTAT, OFF_RES1, OFF_RES2, OFF_PAU1, OFF_PAU2, OFF_DIVLO,
            OFF_DIVHI, OFF_DIVFR, OFF_IRQ_STAT, OFF_IRQ_EN,
            OFF_IRQ_CLR: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction : isMapped

    logic anyRst;
    assign anyRst = srst | porRst;

    // ==========================================================
    // write channel
    ucrs_wstate_e wState_r;
    logic [ADDR_W-1:0] awAddr_r;
    logic [REG_W-1:0] wData_r;
    logic wLane0_r;
    logic doWrite;
    logic wrEn;
    assign doWrite = (wState_r == UCRS_WS_IDLE) && !s_axi_awready && !s_axi_wready;
    assign wrEn = doWrite && wLane0_r;

    always_ff @(posedge clk_sys) begin
        if (anyRst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            wState_r <= UCRS_WS_IDLE;
            awAddr_r <= '0;
            wData_r <= RST_ZERO;
            wLane0_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wData_r <= s_axi_wdata[REG_W-1:0];
                wLane0_r <= s_axi_wstrb[0];
            end
            case (wState_r)
                UCRS_WS_IDLE: begin
                    if (doWrite) begin
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= isMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
                        wState_r <= UCRS_WS_RESP;
                    end
                end
                UCRS_WS_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready <= 1'b1;
                        wState_r <= UCRS_WS_IDLE;
                    end
                end
                default: wState_r <= UCRS_WS_IDLE;
            endcase
        end
    end

    // ==========================================================
    // divisor latches, power-up only
    always_ff @(posedge clk_sys) begin
        if (porRst) begin
            divLow <= RST_DIVLO;
            divHigh <= RST_ZERO;
        end else if (wrEn) begin
            if (awAddr_r == OFF_DIVLO) begin
                divLow <= wData_r;
            end
            if (awAddr_r == OFF_DIVHI) begin
                divHigh <= wData_r;
            end
        end
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge clk_sys) begin
        if (anyRst) begin
            divFrac <= RST_ZERO;
            intEnable <= RST_ZERO;
            fifoCtrl <= RST_ZERO;
            lineCtrl <= RST_ZERO;
            modemCtrl <= RST_ZERO;
            featureCtrl <= RST_ZERO;
            enhFeature <= RST_ZERO;
            txTrigger <= RST_ZERO;
            rxTrigger <= RST_ZERO;
            resumeCharOne <= RST_ZERO;
            resumeCharTwo <= RST_ZERO;
            pauseCharOne <= RST_ZERO;
            pauseCharTwo <= RST_ZERO;
        end else if (wrEn) begin
            case (awAddr_r)
                OFF_DIVFR: divFrac <= wData_r;
                OFF_IER: intEnable <= wData_r;
                OFF_ISR_FCR: fifoCtrl <= wData_r;
                OFF_LCR: lineCtrl <= wData_r;
                OFF_MCR: modemCtrl <= wData_r;
                OFF_FEATURE_CONTROL: featureCtrl <= wData_r;
                OFF_EFR: enhFeature <= wData_r;
                OFF_TXLVL: txTrigger <= wData_r;
                OFF_RXLVL: rxTrigger <= wData_r;
                OFF_RES1: resumeCharOne <= wData_r;
                OFF_RES2: resumeCharTwo <= wData_r;
                OFF_PAU1: pauseCharOne <= wData_r;
                OFF_PAU2: pauseCharTwo <= wData_r;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // scratch register
    logic [REG_W-1:0] scratch_r;
    always_ff @(posedge clk_sys) begin
        if (anyRst) begin
            scratch_r <= RST_SCRATCH;
        end else if (wrEn && awAddr_r == OFF_SCRATCH) begin
            scratch_r <= wData_r;
        end
    end

    // ==========================================================
    // transmit holding strobe
    always_ff @(posedge clk_sys) begin
        if (anyRst) begin
            txHoldStb <= 1'b0;
            txHoldData <= RST_ZERO;
        end else begin
            txHoldStb <= wrEn && awAddr_r == OFF_HOLD;
            if (wrEn && awAddr_r == OFF_HOLD) begin
                txHoldData <= wData_r;
            end
        end
    end

    // ==========================================================
    // serial and modem outputs
    always_ff @(posedge clk_sys) begin
        if (anyRst) begin
            txOut <= 1'b1;
            rtsN <= 1'b1;
            dtrN <= 1'b1;
        end else begin
            txOut <= txSerial;
            rtsN <= ~modemCtrl[MCR_RTS];
            dtrN <= ~modemCtrl[MCR_DTR];
        end
    end

    // ==========================================================
    // read side effects
    logic rdTake;
    logic rdMsr;
    logic rdXstat;
    assign rdTake = s_axi_arvalid && s_axi_arready;
    assign rdMsr = rdTake && s_axi_araddr == OFF_MSR;
    assign rdXstat = rdTake && s_axi_araddr == OFF_XSTAT;

    // ==========================================================
    // status snapshots from the channel
    logic [REG_W-1:0] isrShow_r;
    logic [REG_W-1:0] lsrShow_r;
    logic [REG_W-1:0] txLvl_r;
    logic [REG_W-1:0] rxLvl_r;
    always_ff @(posedge clk_sys) begin
        if (anyRst) begin
            isrShow_r <= RST_ISR;
            lsrShow_r <= RST_LSR;
            txLvl_r <= RST_ZERO;
            rxLvl_r <= RST_ZERO;
        end else begin
            isrShow_r <= isrIn;
            lsrShow_r <= lsrIn;
            txLvl_r <= txLevelIn;
            rxLvl_r <= rxLevelIn;
        end
    end

    // ==========================================================
    // modem status
    logic [MODEM_N-1:0] modemLvl_r;
    logic [MODEM_N-1:0] modemDelta_r;
    logic modemChg;
    assign modemChg = |(modemIn ^ modemLvl_r);
    always_ff @(posedge clk_sys) begin
        modemLvl_r <= modemIn;
    end
    always_ff @(posedge clk_sys) begin
        if (anyRst) begin
            modemDelta_r <= '0;
        end else begin
            modemDelta_r <= (rdMsr ? '0 : modemDelta_r) | (modemIn ^ modemLvl_r);
        end
    end

    // ==========================================================
    // flow character status
    logic [XC_W-1:0] xStat_r;
    logic [XC_W-1:0] xEvt;
    logic swFlowOff;
    assign swFlowOff = enhFeature[EFR_SWFC_LSB +: EFR_SWFC_W] == '0;
    always_comb begin
        xEvt = '0;
        xEvt[XC_RX_XOFF] = rxXoffDet;
        xEvt[XC_RX_XON] = rxXonDet;
        xEvt[XC_TX_XOFF] = txXoffSent;
        xEvt[XC_TX_XON] = txXonSent;
    end
    always_ff @(posedge clk_sys) begin
        if (anyRst || swFlowOff) begin
            xStat_r <= '0;
        // set by event, cleared by read
        end else begin
            xStat_r <= (rdXstat ? '0 : xStat_r) | xEvt;
        end
    end

    // ==========================================================
    // interrupt status, enable and clear
    logic [IRQ_N-1:0] irqStat_r;
    logic [IRQ_N-1:0] irqEn_r;
    logic [IRQ_N-1:0] irqSet;
    logic [IRQ_N-1:0] irqClr;
    assign irqSet = {modemChg, xEvt};
    assign irqClr = (wrEn && awAddr_r == OFF_IRQ_CLR) ? wData_r[IRQ_N-1:0] : '0;
    always_ff @(posedge clk_sys) begin
        if (anyRst) begin
            irqStat_r <= '0;
            irqEn_r <= '0;
            irq <= 1'b0;
        end else begin
            irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
            if (wrEn && awAddr_r == OFF_IRQ_EN) begin
                irqEn_r <= wData_r[IRQ_N-1:0];
            end
            irq <= |(((irqStat_r & ~irqClr) | irqSet) & irqEn_r);
        end
    end

    // ==========================================================
    // read channel
    logic [REG_W-1:0] rdByte;
    always_comb begin
        rdByte = RST_ZERO;
        case (s_axi_araddr)
            OFF_HOLD: rdByte = rxHoldData;
            OFF_IER: rdByte = intEnable;
            OFF_ISR_FCR: rdByte = isrShow_r;
            OFF_LCR: rdByte = lineCtrl;
            OFF_MCR: rdByte = modemCtrl;
            OFF_LSR: rdByte = lsrShow_r;
            OFF_MSR: rdByte = {modemLvl_r, modemDelta_r};
            OFF_SCRATCH: rdByte = scratch_r;
            OFF_FEATURE_CONTROL: rdByte = featureCtrl;
            OFF_EFR: rdByte = enhFeature;
            OFF_TXLVL: rdByte = txLvl_r;
            OFF_RXLVL: rdByte = rxLvl_r;
            OFF_XSTAT: rdByte = {{(REG_W-XC_W){1'b0}}, xStat_r};
            OFF_DIVLO: rdByte = divLow;
            OFF_DIVHI: rdByte = divHigh;
            OFF_DIVFR: rdByte = divFrac;
            OFF_IRQ_STAT: rdByte = {{(REG_W-IRQ_N){1'b0}}, irqStat_r};
            OFF_IRQ_EN: rdByte = {{(REG_W-IRQ_N){1'b0}}, irqEn_r};
            default: rdByte = RST_ZERO;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (anyRst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (rdTake) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {{(DATA_W-REG_W){1'b0}}, rdByte};
            s_axi_rresp <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule : ucrs_top
`default_nettype wire

//--- test/uart_channel_reset_state_tb.sv
// Purpose: self-checking bench for the channel register set
// Assumes: host model drives the register bus
// Notes: random values from an xorshift seeded with 863
`timescale 1ns/1ps
`default_nettype none
module uart_channel_reset_state_tb
    import ucrs_pkg::*;
;
    localparam logic [7:0] RW_LIST [9] = '{OFF_IER, OFF_LCR, OFF_MCR, OFF_FEATURE_CONTROL, OFF_EFR, OFF_DIVFR, OFF_SCRATCH,
        OFF_DIVLO, OFF_DIVHI};
    logic clk_sys, srst, porRst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, hung, txSerial, txOut, rtsN, dtrN, irq;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0] wstrb, ev;
    logic [1:0] bresp, rresp;
    logic [MODEM_N-1:0] modemIn;
    logic [7:0] rxHold, isrV, lsrV, divLow, divHigh, enhFeature, ser;
    logic [7:0] sh [0:31];
    logic [31:0] seed;
    int n_errors, cmp_count;
    ucrs_host host (.*);
    ucrs_top dut (.clk_sys(clk_sys), .srst(srst), .porRst(porRst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .modemIn(modemIn), .rxXoffDet(ev[0]), .rxXonDet(ev[1]), .txXoffSent(ev[2]), .txXonSent(ev[3]),
        .txSerial(txSerial), .rxHoldData(rxHold), .isrIn(isrV), .lsrIn(lsrV), .txLevelIn(lsrV),
        .rxLevelIn(isrV), .txOut(txOut), .rtsN(rtsN), .dtrN(dtrN), .txHoldStb(), .txHoldData(),
        .divLow(divLow), .divHigh(divHigh), .divFrac(), .intEnable(), .fifoCtrl(), .lineCtrl(), .modemCtrl(),
        .featureCtrl(), .enhFeature(enhFeature), .txTrigger(), .rxTrigger(), .resumeCharOne(),
        .resumeCharTwo(), .pauseCharOne(), .pauseCharTwo(), .irq(irq));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        ser <= {ser[6:0], ser[7] ^ ser[5] ^ ser[4] ^ ser[3]};
        txSerial <= ser[0];
        if (hung) begin
            n_errors++;
            summarize();
        end
    end
    // ==========================================================
    // helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic void shReset(input logic por);
        for (int k = 0; k < 7; k++) sh[RW_LIST[k][6:2]] = RST_ZERO;
        sh[OFF_SCRATCH[6:2]] = RST_SCRATCH;
        if (por) begin
            sh[OFF_DIVLO[6:2]] = RST_DIVLO;
            sh[OFF_DIVHI[6:2]] = RST_ZERO;
        end
    endfunction : shReset
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        host.rd(a, d, r);
        chk("read data", d, exp);
        chk("read resp", 32'(r), 32'(RESP_OKAY));
    endtask : rdchk
    task automatic wrreg(input logic [ADDR_W-1:0] a, input logic [7:0] v);
        logic [1:0] r;
        host.wr(a, {24'h0, v}, r);
        chk("write resp", 32'(r), 32'(RESP_OKAY));
        sh[a[6:2]] = v;
    endtask : wrreg
    task automatic checkAll();
        foreach (RW_LIST[k]) rdchk(RW_LIST[k], {24'h0, sh[RW_LIST[k][6:2]]});
    endtask : checkAll
    task automatic doReset(input logic por);
        @(posedge clk_sys);
        srst <= !por;
        porRst <= por;
        repeat (12) @(posedge clk_sys);
        chk("idle outputs", {29'h0, txOut, rtsN, dtrN}, 32'h7);
        srst <= 1'b0;
        porRst <= 1'b0;
        shReset(por);
    endtask : doReset
    task automatic pulse(input int i);
        @(posedge clk_sys);
        ev <= 4'h1 << i;
        @(posedge clk_sys);
        ev <= 4'h0;
    endtask : pulse
    task automatic irqIs(input logic e);
        repeat (2) @(posedge clk_sys);
        chk("irq", {31'h0, irq}, {31'h0, e});
    endtask : irqIs
    task automatic summarize();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] v, d;
        logic [1:0] r;
        logic [3:0] m;
        {n_errors, cmp_count, ev, txSerial} = '0;
        seed = 32'h0000035F;
        ser = 8'hA5;
        srst = 1'b1;
        porRst = 1'b1;
        v = xs();
        {modemIn, rxHold, isrV, lsrV} = v[27:0];
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        porRst <= 1'b0;
        shReset(1'b1);
        checkAll();
        rdchk(OFF_MSR, {24'h0, modemIn, 4'h0});
        rdchk(OFF_XSTAT, 32'h0);
        rdchk(OFF_HOLD, {24'h0, rxHold});
        rdchk(OFF_ISR_FCR, {24'h0, isrV});
        for (int k = 0; k < 12; k++) begin
            v = xs();
            wrreg(RW_LIST[v[11:8] % 9], v[7:0]);
        end
        wrreg(OFF_DIVLO, {1'b1, v[22:16]});
        wrreg(OFF_DIVHI, {1'b1, v[30:24]});
        wrreg(OFF_MCR, 8'h03);
        repeat (2) @(posedge clk_sys);
        chk("modem outputs", {30'h0, rtsN, dtrN}, 32'h0);
        doReset(1'b0);
        chk("divisor ports", {16'h0, divHigh, divLow}, {16'h0, sh[OFF_DIVHI[6:2]], sh[OFF_DIVLO[6:2]]});
        checkAll();
        doReset(1'b1);
        checkAll();
        wrreg(OFF_EFR, 8'h0A);
        wrreg(OFF_IRQ_EN, 8'h0F);
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            rdchk(OFF_XSTAT, 32'h1 << i);
            irqIs(1'b1);
            wrreg(OFF_IRQ_CLR, 8'h01 << i);
            irqIs(1'b0);
            rdchk(OFF_XSTAT, 32'h0);
        end
        pulse(0);
        wrreg(OFF_IRQ_EN, 8'h00);
        irqIs(1'b0);
        rdchk(OFF_IRQ_STAT, 32'h1);
        wrreg(OFF_IRQ_EN, 8'h01);
        irqIs(1'b1);
        wrreg(OFF_EFR, 8'h00);
        rdchk(OFF_XSTAT, 32'h0);
        pulse(0);
        rdchk(OFF_XSTAT, 32'h0);
        wrreg(OFF_IRQ_CLR, 8'h1F);
        irqIs(1'b0);
        v = xs();
        m = modemIn ^ (v[3:0] | 4'h1);
        d = {28'h0, modemIn};
        modemIn <= m;
        repeat (3) @(posedge clk_sys);
        rdchk(OFF_MSR, {24'h0, m, m ^ d[3:0]});
        rdchk(OFF_MSR, {24'h0, m, 4'h0});
        rdchk(OFF_IRQ_STAT, 32'h10);
        host.rd(8'h5C, d, r);
        chk("unmapped read", {d[29:0], r}, {30'h0, RESP_SLVERR});
        host.wr(8'h60, 32'hFFFFFFFF, r);
        chk("unmapped write", 32'(r), 32'(RESP_SLVERR));
        summarize();
    end
endmodule : uart_channel_reset_state_tb
`default_nettype wire

//--- test/ucrs_host.sv
// Purpose: host processor model, axi4-lite master
// Assumes: nba changes after a rising edge
// Notes: hung rises when an answer never comes
`timescale 1ns/1ps
`default_nettype none
module ucrs_host
    import ucrs_pkg::*;
(
    input wire logic clk_sys,
    output logic [ADDR_W-1:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [DATA_W-1:0] wdata,
    output logic [DATA_W/8-1:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [ADDR_W-1:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready,
    output logic hung
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready, hung} = '0;
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [1:0] r);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        r = 2'h3;
        @(posedge clk_sys);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge clk_sys);
            n++;
            // released lines stop showing the last value
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end else if (n > 60) begin
                hung <= 1'b1;
                done = 1'b1;
            end
        end
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        r = 2'h3;
        d = '0;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clk_sys);
            n++;
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end else if (n > 60) begin
                hung <= 1'b1;
                done = 1'b1;
            end
        end
    endtask : rd
endmodule : ucrs_host
`default_nettype wire

//--- test/ucrs_top_asserts.sv
// Purpose: port checks
// Assumes: one clock domain
// Notes: attached to ucrs_top by bind
`timescale 1ns/1ps
`default_nettype none
module ucrs_top_asserts
    import ucrs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic porRst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic [MODEM_N-1:0] modemIn,
    input wire logic rxXoffDet,
    input wire logic txSerial,
    input wire logic txOut,
    input wire logic rtsN,
    input wire logic dtrN,
    input wire logic [REG_W-1:0] divLow,
    input wire logic [REG_W-1:0] divHigh,
    input wire logic [REG_W-1:0] enhFeature,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst || porRst);
    logic arTake;
    assign arTake = s_axi_arvalid && s_axi_arready;
    // ==========================================================
    // assertions
    AST_TX_IDLE: assert property (disable iff (1'b0) (srst || porRst) |=> txOut && rtsN && dtrN)
        else $error("outputs not idle high in reset");
    AST_DIV_POR: assert property (disable iff (1'b0) porRst |=> divLow == 8'h01 && divHigh == 8'h00)
        else $error("divisor not loaded by power-up reset");
    AST_DIV_KEEP: assert property (disable iff (1'b0) (srst && !porRst) |=> $stable(divLow) && $stable(divHigh))
        else $error("divisor changed by reset pin");
    AST_XOFF_SEEN: assert property ((rxXoffDet && enhFeature[3:0] != 4'h0 ##2 arTake && s_axi_araddr == OFF_XSTAT)
        |=> s_axi_rdata[XC_RX_XOFF]) else $error("received xoff not reported");
    AST_FLOW_ZERO: assert property ((arTake && s_axi_araddr == OFF_XSTAT && $past(enhFeature[3:0]) == 4'h0)
        |=> s_axi_rdata[7:0] == 8'h00) else $error("flow status not zero");
    AST_MSR_LEVEL: assert property ((arTake && s_axi_araddr == OFF_MSR && $stable(modemIn))
        |=> s_axi_rdata[7:4] == $past(modemIn)) else $error("modem levels wrong");
    AST_WR_RESP: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
        |-> ##2 s_axi_bvalid) else $error("write response late");
    AST_RD_SLVERR: assert property ((arTake && (s_axi_araddr > OFF_IRQ_CLR || s_axi_araddr[1:0] != 2'h0))
        |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
    AST_TX_FOLLOW: assert property ((!$past(srst) && !$past(porRst)) |-> txOut == $past(txSerial))
        else $error("serial out lag");
    AST_AW_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while busy");
    CVR_IRQ: cover property ($rose(irq));
    CVR_SRST: cover property (disable iff (1'b0) srst && !porRst ##1 !srst);
    CVR_MSR: cover property (arTake && s_axi_araddr == OFF_MSR);
endmodule : ucrs_top_asserts
bind ucrs_top ucrs_top_asserts u_asserts (.*);
`default_nettype wire
